// File: hbf_framer.sv
// hdlc byte framer and deframer with apb register port
`timescale 1ns/1ps

// Operation
// RL1: frame goes out as opening flag, data bytes, two checksum bytes, closing flag.
// RL2: flag symbol is byte 7E marking frame start and end.
// RL3: receiver flags abort on more than six consecutive ones.
// RL4: with no data pending the transmitter keeps sending flags.
// RL5: transmitter inserts a zero after five ones inside a frame.
// RL6: receiver deletes the zero following five ones.
// RL7: two checksum bytes follow the last data byte, then the closing flag.
// RL8: checksum covers unstuffed frame bits only.
// RL9: one flag may close a frame and open the next.
// RL10: framing off after reset; runs only with parallel port select set.
// RL11: host enables framing, clears buffer bits 8..15, reads data once.
// RL12: tx request flag raised when ready, interrupt if enabled; host writes then.
// RL13: with no further byte, frame-close status set; checksum and flag follow.
// RL14: frame-close set no earlier than 8 bit times after tx request rose.
// RL15: frame-close cleared when closing flag starts; done 8 bit times later.
// RL16: rx available flag set per received byte, interrupt if enabled.
// RL17: host reads status before data; status may change after data read.
// RL18: fault 0 and end-of-frame 0 mean an ordinary frame byte.
// RL19: end-of-frame 1 with fault 0 means good checksum; prior two bytes are checksum.
// RL20: abort reported as data FF, checksum failure as data 7E, with fault set.
// RL21: checksum polynomial x16+x12+x5+1, preset ones, complement sent.
// RL22: bytes go out least significant bit first.
module hbf_framer #(
  parameter int BIT_DIV = hbf_pkg::BIT_DIV_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host interrupt
  output logic hbf_irq,
  // synchronous bit stream
  output logic ser_tx_data,
  output logic ser_bit_tick,
  input wire logic ser_rx_data
);

  if (BIT_DIV < 2 || BIT_DIV >= (1 << hbf_pkg::DIV_W))
  begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  localparam logic [hbf_pkg::DIV_W-1:0] DIV_LAST = hbf_pkg::DIV_W'(BIT_DIV - 1);

  hbf_pkg::hbf_state_t s_reg;
  hbf_pkg::hbf_state_t s_next;
  logic tick;
  logic active;
  logic setup_ph;
  logic access_ph;

  assign tick = (s_reg.div == DIV_LAST);
  assign active = s_reg.hdlc_en & s_reg.pps;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;

  always_comb
  begin
    logic b;
    logic outb;
    logic append;
    logic rx_flag;
    logic rx_abort;
    logic [7:0] rbyte;
    logic [31:0] rd;
    logic bad;
    b = ser_rx_data;
    outb = 1'b1;
    append = 1'b0;
    rx_flag = 1'b0;
    rx_abort = 1'b0;
    rbyte = 8'h00;
    rd = 32'h0000_0000;
    bad = 1'b0;
    s_next = s_reg;
    s_next.div = tick ? '0 : s_reg.div + 1'b1;

    // register writes and the read side effect take place in the access phase
    if (access_ph)
    begin
      if (paddr == hbf_pkg::OFS_HOST_BYTE_PORT)
      begin
        if (!pwrite)
        begin
          s_next.ravail = 1'b0;
        end
        else if (s_reg.tx_req && !s_reg.tx_full)
        begin
          s_next.tx_full = 1'b1; // RL12
          s_next.tx_hold = pwdata[7:0];
        end
      end
      else if (paddr == hbf_pkg::OFS_HOST_CONTROL)
      begin
        if (pwrite)
        begin
          s_next.pps = pwdata[hbf_pkg::CTL_PARALLEL_PORT_SELECT];
          s_next.tx_request_irq_enable = pwdata[hbf_pkg::CTL_TX_REQUEST_IRQ_ENABLE];
          s_next.rx_available_irq_enable = pwdata[hbf_pkg::CTL_RX_AVAILABLE_IRQ_ENABLE];
        end
      end
      else if (paddr == hbf_pkg::OFS_BUFFER_CONTROL)
      begin
        if (pwrite)
        begin
          s_next.hdlc_en = pwdata[hbf_pkg::BUF_FRAMING_ENABLE];
          s_next.buf_high = pwdata[hbf_pkg::BUF_HIGH_LSB +: 8];
        end
      end
    end

    // transmitter: one bit per tick, stuffing takes precedence over data
    if (!active)
    begin
      s_next.txk = hbf_pkg::TXK_FLAG; // RL10
      s_next.tsh = hbf_pkg::FLAG_BYTE;
      s_next.tbit = 3'd0;
      s_next.tones = 3'd0;
      s_next.tx_full = 1'b0;
      s_next.fclose = 1'b0;
      s_next.tdata = 1'b1;
    end
    else if (tick)
    begin
      if (s_reg.tones == hbf_pkg::STUFF_RUN)
      begin
        outb = 1'b0; // RL5
        s_next.tones = 3'd0;
      end
      else
      begin
        outb = s_reg.tsh[0]; // RL22
        if (s_reg.txk == hbf_pkg::TXK_FLAG)
        begin
          s_next.tones = 3'd0;
        end
        else
        begin
          s_next.tones = outb ? s_reg.tones + 3'd1 : 3'd0;
        end
        if (s_reg.txk == hbf_pkg::TXK_DATA)
        begin
          s_next.tcrc = hbf_pkg::hbf_crc_bit(s_reg.tcrc, outb); // RL8
        end
        s_next.tsh = s_reg.tsh >> 1;
        s_next.tbit = s_reg.tbit + 3'd1;
        if (s_reg.tbit == 3'd7)
        begin
          case (s_reg.txk)
            hbf_pkg::TXK_FLAG:
            begin
              if (s_reg.tx_full)
              begin
                s_next.txk = hbf_pkg::TXK_DATA; // RL9
                s_next.tsh = s_reg.tx_hold;
                s_next.tx_full = 1'b0;
                s_next.tcrc = hbf_pkg::CRC_PRESET; // RL21
              end
              else
              begin
                s_next.tsh = hbf_pkg::FLAG_BYTE; // RL4
              end
            end
            hbf_pkg::TXK_DATA:
            begin
              if (s_reg.tx_full)
              begin
                s_next.tsh = s_reg.tx_hold;
                s_next.tx_full = 1'b0;
              end
              else
              begin
                s_next.fclose = 1'b1; // RL13 RL14
                s_next.txk = hbf_pkg::TXK_CRC1; // RL7
                s_next.tsh = ~s_next.tcrc[7:0]; // RL21
              end
            end
            hbf_pkg::TXK_CRC1:
            begin
              s_next.txk = hbf_pkg::TXK_CRC2;
              s_next.tsh = ~s_reg.tcrc[15:8];
            end
            default:
            begin
              s_next.txk = hbf_pkg::TXK_FLAG; // RL1
              s_next.tsh = hbf_pkg::FLAG_BYTE; // RL2
              s_next.fclose = 1'b0; // RL15
            end
          endcase
        end
      end
      s_next.tdata = outb;
    end

    // tx request and the bit-time count since it last rose
    s_next.tx_req = active & ~s_next.tx_full; // RL12
    if (s_next.tx_req && !s_reg.tx_req)
    begin
      s_next.since = 4'd0;
    end
    else if (tick && s_reg.since != hbf_pkg::CLOSE_GAP_BITS)
    begin
      s_next.since = s_reg.since + 4'd1;
    end

    // receiver: run length of ones separates data, stuffing, flags and aborts
    if (!active)
    begin
      s_next.rones = 3'd0;
      s_next.rin = 1'b0;
      s_next.rcnt = 3'd0;
      s_next.rnb = 2'd0;
    end
    else if (tick)
    begin
      if (b)
      begin
        s_next.rones = (s_reg.rones == hbf_pkg::ABORT_RUN) ? s_reg.rones : s_reg.rones + 3'd1;
        if (s_reg.rones == hbf_pkg::FLAG_RUN)
        begin
          rx_abort = 1'b1; // RL3
        end
        else if (s_reg.rones != hbf_pkg::ABORT_RUN)
        begin
          append = 1'b1;
        end
      end
      else
      begin
        s_next.rones = 3'd0;
        if (s_reg.rones == hbf_pkg::FLAG_RUN)
        begin
          rx_flag = 1'b1;
        end
        else if (s_reg.rones != hbf_pkg::STUFF_RUN)
        begin
          append = 1'b1; // RL6
        end
      end

      if (rx_abort && s_reg.rin)
      begin
        s_next.rin = 1'b0;
        if (s_reg.rnb != 2'd0)
        begin
          s_next.rdata = hbf_pkg::ABORT_BYTE; // RL20
          s_next.reof = 1'b0;
          s_next.rfault = 1'b1;
          s_next.ravail = 1'b1; // RL16
        end
      end
      else if (rx_flag)
      begin
        if (s_reg.rin && s_reg.rnb != 2'd0)
        begin
          bad = (s_reg.rcnt != 3'd7) || (s_reg.rnb < 2'd2) || (s_reg.rcrc != hbf_pkg::CRC_RESIDUE);
          s_next.rdata = hbf_pkg::CRC_FAIL_BYTE; // RL19 RL20
          s_next.reof = 1'b1;
          s_next.rfault = bad;
          s_next.ravail = 1'b1;
        end
        s_next.rin = 1'b1;
        s_next.rcnt = 3'd0;
        s_next.rnb = 2'd0;
        s_next.rcrc = hbf_pkg::CRC_PRESET;
      end
      else if (append && s_reg.rin)
      begin
        rbyte = {b, s_reg.rsh[7:1]};
        s_next.rsh = rbyte;
        s_next.rcnt = s_reg.rcnt + 3'd1;
        if (s_reg.rcnt == 3'd7)
        begin
          s_next.rdata = rbyte;
          s_next.reof = 1'b0; // RL18
          s_next.rfault = 1'b0;
          s_next.ravail = 1'b1; // RL16
          s_next.rcrc = hbf_pkg::hbf_crc_byte(s_reg.rcrc, rbyte); // RL8
          s_next.rnb = (s_reg.rnb == 2'd3) ? s_reg.rnb : s_reg.rnb + 2'd1;
        end
      end
    end

    s_next.irq = (s_next.tx_req & s_next.tx_request_irq_enable) | (s_next.ravail & s_next.rx_available_irq_enable); // RL12 RL16

    // read data is captured in the setup phase from the freshest state, so a byte
    // that lands in that cycle is read, not dropped by the access-phase clear
    if (setup_ph)
    begin
      s_next.pslverr = 1'b0;
      if (paddr == hbf_pkg::OFS_HOST_BYTE_PORT)
      begin
        rd[7:0] = s_next.rdata;
      end
      else if (paddr == hbf_pkg::OFS_HOST_CONTROL)
      begin
        rd[hbf_pkg::CTL_PARALLEL_PORT_SELECT] = s_next.pps;
        rd[hbf_pkg::CTL_TX_REQUEST_IRQ_ENABLE] = s_next.tx_request_irq_enable;
        rd[hbf_pkg::CTL_RX_AVAILABLE_IRQ_ENABLE] = s_next.rx_available_irq_enable;
      end
      else if (paddr == hbf_pkg::OFS_HOST_FLAG)
      begin
        rd[hbf_pkg::FLG_TX_BYTE_REQUEST] = s_next.tx_req;
        rd[hbf_pkg::FLG_RX_BYTE_AVAILABLE] = s_next.ravail;
      end
      else if (paddr == hbf_pkg::OFS_FRAMING_STATUS)
      begin
        rd[hbf_pkg::STS_FRAME_CLOSE] = s_next.fclose;
        rd[hbf_pkg::STS_RX_END_OF_FRAME] = s_next.reof; // RL17
        rd[hbf_pkg::STS_RX_FRAME_FAULT] = s_next.rfault;
      end
      else if (paddr == hbf_pkg::OFS_BUFFER_CONTROL)
      begin
        rd[hbf_pkg::BUF_FRAMING_ENABLE] = s_next.hdlc_en;
        rd[hbf_pkg::BUF_HIGH_LSB +: 8] = s_next.buf_high;
      end
      else
      begin
        s_next.pslverr = 1'b1;
      end
      s_next.prdata = rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0; // RL10
      s_reg.txk <= hbf_pkg::TXK_FLAG;
      s_reg.tsh <= hbf_pkg::FLAG_BYTE;
      s_reg.tdata <= 1'b1;
      s_reg.buf_high <= hbf_pkg::RST_BUF_HIGH;
      s_reg.prdata <= hbf_pkg::RST_PRDATA;
      s_reg.tcrc <= hbf_pkg::CRC_PRESET;
      s_reg.rcrc <= hbf_pkg::CRC_PRESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr & access_ph;
  assign hbf_irq = s_reg.irq;
  assign ser_tx_data = s_reg.tdata;
  assign ser_bit_tick = tick;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_FLAG_VALUE: assert property (active && tick && s_reg.txk == hbf_pkg::TXK_FLAG && s_reg.tbit == 3'd0 // RL2
    && s_reg.tones != hbf_pkg::STUFF_RUN |-> s_reg.tsh == hbf_pkg::FLAG_BYTE)
    else $error("flag byte is not 7E");
  AST_STUFF_LIMIT: assert property (s_reg.tones <= hbf_pkg::STUFF_RUN) // RL5
    else $error("more than five ones sent");
  AST_STUFF_ZERO: assert property (active && tick && s_reg.tones == hbf_pkg::STUFF_RUN |=> !ser_tx_data) // RL5
    else $error("stuffed zero missing");
  AST_CRC_ORDER: assert property (s_reg.txk == hbf_pkg::TXK_CRC1 && s_next.txk != hbf_pkg::TXK_CRC1 && active // RL7
    |=> s_reg.txk == hbf_pkg::TXK_CRC2)
    else $error("second checksum byte not after first");
  AST_CLOSE_GAP: assert property ($rose(s_reg.fclose) |-> s_reg.since >= hbf_pkg::CLOSE_GAP_BITS) // RL14
    else $error("frame close set too early");
  AST_CLOSE_CLEAR: assert property ($fell(s_reg.fclose) && active |-> s_reg.txk == hbf_pkg::TXK_FLAG // RL15
    && $past(s_reg.txk) == hbf_pkg::TXK_CRC2)
    else $error("frame close cleared outside closing flag");
  AST_DISABLED: assert property (!active |=> !s_reg.tx_req && !s_reg.fclose) // RL10
    else $error("framing runs while disabled");
  AST_ABORT_REPORT: assert property (active && tick && ser_rx_data && s_reg.rones == hbf_pkg::FLAG_RUN // RL3
    && s_reg.rin && s_reg.rnb != 2'd0 |=> s_reg.ravail && s_reg.rfault && s_reg.rdata == hbf_pkg::ABORT_BYTE)
    else $error("abort not reported");
  AST_RX_BYTE: assert property (active && tick && s_reg.rin && s_reg.rcnt == 3'd7 && s_reg.rones < 3'd5 // RL16
    && !ser_rx_data |=> s_reg.ravail && !s_reg.reof && !s_reg.rfault)
    else $error("received byte not flagged available");
  AST_IRQ: assert property (s_reg.ravail && s_reg.rx_available_irq_enable |-> hbf_irq) // RL16
    else $error("rx interrupt missing");

  COV_FRAME_CLOSED: cover property ($fell(s_reg.fclose));
  COV_GOOD_FRAME: cover property (s_reg.ravail && s_reg.reof && !s_reg.rfault);
  COV_ABORT: cover property (s_reg.ravail && s_reg.rfault && s_reg.rdata == hbf_pkg::ABORT_BYTE);
  COV_STUFF: cover property (active && tick && s_reg.tones == hbf_pkg::STUFF_RUN);

endmodule

// File: hbf_pkg.sv
// constants, types and checksum helpers for the hdlc byte framer
package hbf_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_HOST_BYTE_PORT = 12'h000;
  localparam logic [11:0] OFS_HOST_CONTROL = 12'h004;
  localparam logic [11:0] OFS_HOST_FLAG = 12'h008;
  localparam logic [11:0] OFS_FRAMING_STATUS = 12'h00C;
  localparam logic [11:0] OFS_BUFFER_CONTROL = 12'h010;

  // host_control_register fields
  localparam int CTL_PARALLEL_PORT_SELECT = 0;
  localparam int CTL_TX_REQUEST_IRQ_ENABLE = 1;
  localparam int CTL_RX_AVAILABLE_IRQ_ENABLE = 2;
  // host_flag_register fields
  localparam int FLG_TX_BYTE_REQUEST = 0;
  localparam int FLG_RX_BYTE_AVAILABLE = 1;
  // framing_status_register fields
  localparam int STS_FRAME_CLOSE = 0;
  localparam int STS_RX_END_OF_FRAME = 1;
  localparam int STS_RX_FRAME_FAULT = 2;
  // buffer control word fields
  localparam int BUF_FRAMING_ENABLE = 0;
  localparam int BUF_HIGH_LSB = 8;

  // reset values
  localparam logic [7:0] RST_BUF_HIGH = 8'h00;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // framing symbols and checksum
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ABORT_BYTE = 8'hFF;
  localparam logic [7:0] CRC_FAIL_BYTE = 8'h7E;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
  localparam logic [2:0] STUFF_RUN = 3'd5;
  localparam logic [2:0] FLAG_RUN = 3'd6;
  localparam logic [2:0] ABORT_RUN = 3'd7;
  localparam logic [3:0] CLOSE_GAP_BITS = 4'd8;

  // timing: bit rate of the synchronous stream against pclk
  localparam int CLK_HZ = 25000000;
  localparam int BIT_RATE_BPS = 2400;
  localparam int BIT_DIV_DEF = CLK_HZ / BIT_RATE_BPS;
  localparam int DIV_W = 16;

  typedef enum logic [1:0] {TXK_FLAG, TXK_DATA, TXK_CRC1, TXK_CRC2} hbf_txk_t;

  typedef struct packed {
    logic pps;
    logic tx_request_irq_enable;
    logic rx_available_irq_enable;
    logic hdlc_en;
    logic [7:0] buf_high;
    logic [DIV_W-1:0] div;
    logic tx_full;
    logic [7:0] tx_hold;
    logic tx_req;
    hbf_txk_t txk;
    logic [7:0] tsh;
    logic [2:0] tbit;
    logic [2:0] tones;
    logic [15:0] tcrc;
    logic tdata;
    logic fclose;
    logic [3:0] since;
    logic [2:0] rones;
    logic rin;
    logic [7:0] rsh;
    logic [2:0] rcnt;
    logic [15:0] rcrc;
    logic [1:0] rnb;
    logic [7:0] rdata;
    logic ravail;
    logic reof;
    logic rfault;
    logic irq;
    logic [31:0] prdata;
    logic pslverr;
  } hbf_state_t;

  // reflected crc step, one bit, lsb first
  function automatic logic [15:0] hbf_crc_bit(input logic [15:0] c, input logic b);
    hbf_crc_bit = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC_POLY_REV : 16'h0000);
  endfunction

  function automatic logic [15:0] hbf_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = hbf_crc_bit(r, d[i]);
    end
    hbf_crc_byte = r;
  endfunction

endpackage

// File: hbf_stream_model.sv
// far-end model of the synchronous stream: idle flags, injected bits, loopback and tx decoding
`timescale 1ns/1ps
module hbf_stream_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bit stream
  input wire logic ser_bit_tick,
  input wire logic ser_tx_data,
  output logic ser_rx_data,
  // mode
  input wire logic loop_en
);
  localparam logic [7:0] IDLE = 8'h7E;
  bit inq[$];
  logic [7:0] txq[$];
  int flag_cnt;
  int ones;
  int cnt;
  bit sync;
  bit b;
  logic [7:0] win;
  logic [7:0] sh;
  logic [2:0] idx;

  task automatic push_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      inq.push_back(v[i]);
  endtask

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_rx_data <= 1'b1;
      idx <= 3'd0;
      flag_cnt = 0;
      ones = 0;
      cnt = 0;
      sync = 1'b0;
      win = 8'h00;
    end
    else if (ser_bit_tick)
    begin
      // injected bits start on a flag boundary so the idle stream never splices into them
      if (inq.size() > 0 && idx == 3'd0)
        ser_rx_data <= inq.pop_front();
      else if (loop_en)
        ser_rx_data <= ser_tx_data;
      else
      begin
        ser_rx_data <= IDLE[idx];
        idx <= idx + 3'd1;
      end
      b = ser_tx_data;
      win = {b, win[7:1]};
      if (win == 8'h7E)
      begin
        flag_cnt++;
        sync = 1'b1;
        cnt = 0;
      end
      else if (sync && !(b == 1'b0 && ones == 5))
      begin
        sh = {b, sh[7:1]};
        cnt++;
        if (cnt == 8)
        begin
          txq.push_back(sh);
          cnt = 0;
        end
      end
      ones = b ? ones + 1 : 0;
      if (ones > 6)
        sync = 1'b0;
    end
  end
endmodule

// File: tb_top.sv
// self-checking testbench for the hdlc byte framer
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hbf_irq;
  logic ser_tx_data;
  logic ser_bit_tick;
  logic ser_rx_data;
  logic loop_en = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nw = 0;
  int nr = 0;
  int ticks = 0;
  int t0 = 0;
  logic [31:0] rd;
  logic se;
  logic seen_close = 1'b0;
  logic [15:0] crc;
  logic [7:0] dat[4] = '{8'h7E, 8'hFF, 8'h00, 8'hF8};
  logic [7:0] exp_q[$];

  always #20 pclk = ~pclk;

  hbf_framer #(.BIT_DIV(DIV)) u_hbf_framer (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hbf_irq(hbf_irq), .ser_tx_data(ser_tx_data), .ser_bit_tick(ser_bit_tick), .ser_rx_data(ser_rx_data));
  hbf_stream_model u_hbf_stream_model (.pclk(pclk), .presetn(presetn), .ser_bit_tick(ser_bit_tick),
    .ser_tx_data(ser_tx_data), .ser_rx_data(ser_rx_data), .loop_en(loop_en));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (ser_bit_tick === 1'b1)
      ticks++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(name, exp, rd);
  endtask

  // status is always read before data so the pair belongs to one byte
  task automatic rx_get(input logic [7:0] ed, input logic [1:0] es);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[hbf_pkg::FLG_RX_BYTE_AVAILABLE] !== 1'b1 && n < 400)
    begin
      apb(1'b0, hbf_pkg::OFS_HOST_FLAG, 32'h0000_0000);
      n++;
    end
    apb(1'b0, hbf_pkg::OFS_FRAMING_STATUS, 32'h0000_0000);
    seen_close = seen_close | rd[hbf_pkg::STS_FRAME_CLOSE];
    chk_val("rx status", 32'(es), 32'(rd[2:1]));
    rdc("rx data", hbf_pkg::OFS_HOST_BYTE_PORT, 32'(ed));
  endtask

  function automatic logic [15:0] fcs(input logic [7:0] d[4]);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 32; i++)
      c = (c >> 1) ^ (((c[0] ^ d[i / 8][i % 8]) == 1'b1) ? 16'h8408 : 16'h0000);
    return ~c;
  endfunction

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("control", hbf_pkg::OFS_HOST_CONTROL, 32'h0000_0000);
    rdc("buffer control", hbf_pkg::OFS_BUFFER_CONTROL, 32'h0000_0000);
    rdc("framing status", hbf_pkg::OFS_FRAMING_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk_bit("unmapped error", 1'b1, se);
    apb(1'b1, hbf_pkg::OFS_BUFFER_CONTROL, 32'h0000_FF01);
    rdc("buffer control", hbf_pkg::OFS_BUFFER_CONTROL, 32'h0000_FF01);
    apb(1'b1, hbf_pkg::OFS_BUFFER_CONTROL, 32'h0000_0001);
    @(negedge pclk);
    t0 = ticks;
    repeat (20 * DIV) @(posedge pclk);
    @(negedge pclk);
    chk_val("flags unselected", 32'h0000_0000, 32'(u_hbf_stream_model.flag_cnt));
    chk_bit("tx line unselected", 1'b1, ser_tx_data);
    chk_val("bit ticks", 32'h0000_0014, 32'(ticks - t0));
    apb(1'b1, hbf_pkg::OFS_HOST_CONTROL, 32'h0000_0003);
    apb(1'b0, hbf_pkg::OFS_HOST_BYTE_PORT, 32'h0000_0000);
    repeat (30 * DIV) @(posedge pclk);
    @(negedge pclk);
    chk_bit("idle flags", 1'b1, u_hbf_stream_model.flag_cnt >= 2);
    apb(1'b0, hbf_pkg::OFS_HOST_FLAG, 32'h0000_0000);
    chk_bit("tx request", 1'b1, rd[hbf_pkg::FLG_TX_BYTE_REQUEST]);
    chk_bit("tx request irq", 1'b1, hbf_irq);
    // abort after one byte, then a frame whose check bytes are wrong
    u_hbf_stream_model.push_byte(8'h7E);
    u_hbf_stream_model.push_byte(8'h55);
    u_hbf_stream_model.push_byte(8'hFF);
    rx_get(8'h55, 2'b00);
    rx_get(8'hFF, 2'b10);
    u_hbf_stream_model.push_byte(8'h7E);
    u_hbf_stream_model.push_byte(8'h1F);
    u_hbf_stream_model.inq.push_back(1'b0);
    u_hbf_stream_model.push_byte(8'h22);
    u_hbf_stream_model.push_byte(8'h33);
    u_hbf_stream_model.push_byte(8'h7E);
    rx_get(8'h1F, 2'b00);
    rx_get(8'h22, 2'b00);
    rx_get(8'h33, 2'b00);
    rx_get(8'h7E, 2'b11);
    // loopback: the switch may leave one stray byte, so let it settle and drain it
    loop_en <= 1'b1;
    repeat (60 * DIV) @(posedge pclk);
    apb(1'b0, hbf_pkg::OFS_HOST_BYTE_PORT, 32'h0000_0000);
    apb(1'b1, hbf_pkg::OFS_HOST_CONTROL, 32'h0000_0005);
    crc = fcs(dat);
    foreach (dat[i])
      exp_q.push_back(dat[i]);
    exp_q.push_back(crc[7:0]);
    exp_q.push_back(crc[15:8]);
    exp_q.push_back(8'h7E);
    while (nr < 7)
    begin
      apb(1'b0, hbf_pkg::OFS_HOST_FLAG, 32'h0000_0000);
      if (rd[hbf_pkg::FLG_RX_BYTE_AVAILABLE] === 1'b1)
      begin
        chk_bit("rx irq", 1'b1, hbf_irq);
        rx_get(exp_q[nr], (nr == 6) ? 2'b01 : 2'b00);
        nr++;
      end
      else if (rd[hbf_pkg::FLG_TX_BYTE_REQUEST] === 1'b1 && nw < 4)
      begin
        apb(1'b1, hbf_pkg::OFS_HOST_BYTE_PORT, {24'h00_0000, dat[nw]});
        nw++;
      end
    end
    chk_bit("frame close seen", 1'b1, seen_close);
    repeat (16 * DIV) @(posedge pclk);
    @(negedge pclk);
    chk_val("wire byte count", 32'h0000_0006, 32'(u_hbf_stream_model.txq.size()));
    for (int i = 0; i < 6; i++)
      chk_val("wire byte", 32'(exp_q[i]), 32'(u_hbf_stream_model.txq[i]));
    results();
  end
endmodule
